//--- design/rgc_consts.vh
`ifndef RGC_CONSTS_VH
`define RGC_CONSTS_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RGC_ADDR_PROT    8'h3d
`define RGC_ADDR_MODE    8'h4c
`define RGC_ADDR_ALERT   8'h4e

// ------------------------------------------------------------
// reset values and writable masks
// ------------------------------------------------------------
`define RGC_PROT_RESET   16'h0000
`define RGC_MODE_RESET   16'h0000
`define RGC_ALERT_RESET  16'h0000
`define RGC_PROT_MASK    16'hffdb
`define RGC_MODE_MASK    16'h9f6b
`define RGC_ALERT_MASK   16'h00c1

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RGC_P_OV_DIS     15
`define RGC_P_UV_DIS     14
`define RGC_P_REV_RST    13
`define RGC_P_FAST_RST   12
`define RGC_P_FWD_RST    11
`define RGC_P_DEB_HI     10
`define RGC_P_DEB_LO     9
`define RGC_P_DUR_HI     8
`define RGC_P_DUR_LO     6
`define RGC_P_REV_SWAP   4
`define RGC_P_FWD_SWAP   3
`define RGC_P_WOC_DIS    1
`define RGC_P_WOC_THR    0
`define RGC_M_NO_REREAD  15
`define RGC_M_REV_START  12
`define RGC_M_FWD_START  11
`define RGC_M_FORCE_HI   10
`define RGC_M_FORCE_LO   8
`define RGC_M_GAIN_HALF  6
`define RGC_M_ILIM_DIS   5
`define RGC_M_REF_OFF    3
`define RGC_M_DIG_RST    2
`define RGC_M_PER_DBL    1
`define RGC_M_PG_EARLY   0
`define RGC_A_REV_CUR    7
`define RGC_A_SLEEP      6
`define RGC_A_CLEAR      1
`define RGC_A_LATCH      0

// ------------------------------------------------------------
// timing, in microseconds, at the core clock rate
// ------------------------------------------------------------
`define RGC_CLK_MHZ      50
`define RGC_T_SLOW_US    1300000
`define RGC_T_MID_US     150000
`define RGC_T_200_US     200
`define RGC_T_10_US      10
`define RGC_T_DEB0_US    7
`define RGC_T_DEB1_US    100
`define RGC_T_DEB2_US    500
`define RGC_T_DEB3_US    1000
`define RGC_T_DUR0_US    10000
`define RGC_T_DUR1_US    20000
`define RGC_T_DUR2_US    15000
`define RGC_T_DUR3_US    5000
`define RGC_T_DUR4_US    1000
`define RGC_T_DUR5_US    500
`define RGC_T_DUR6_US    100
`define RGC_CYC(us)      ((us) * `RGC_CLK_MHZ)

`endif

//--- design/rgc_timer.v
`default_nettype none

module rgc_timer #(
	parameter W = 27
) (
	input  wire         clk,
	input  wire         rst,
	input  wire         start,
	input  wire [W-1:0] loadVal,
	output reg          busy,
	output reg          done
);

	reg [W-1:0] cnt_q;

	// a new start restarts the count from the fresh value
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= {W{1'b0}};
			busy  <= 1'b0;
			done  <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start) begin
				cnt_q <= loadVal;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
					busy <= 1'b0;
					done <= 1'b1;
				end else begin
					cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end

endmodule
`default_nettype wire

//--- design/rgc_regulator_ctrl.v
`include "rgc_consts.vh"
`default_nettype none

module rgc_regulator_ctrl #(
	parameter W          = 27,
	parameter SLOW_CYC   = `RGC_CYC(`RGC_T_SLOW_US),
	parameter MID_CYC    = `RGC_CYC(`RGC_T_MID_US),
	parameter T200_CYC   = `RGC_CYC(`RGC_T_200_US),
	parameter DEB1_CYC   = `RGC_CYC(`RGC_T_DEB1_US),
	parameter DEB2_CYC   = `RGC_CYC(`RGC_T_DEB2_US),
	parameter DEB3_CYC   = `RGC_CYC(`RGC_T_DEB3_US),
	parameter DUR0_CYC   = `RGC_CYC(`RGC_T_DUR0_US),
	parameter DUR1_CYC   = `RGC_CYC(`RGC_T_DUR1_US),
	parameter DUR2_CYC   = `RGC_CYC(`RGC_T_DUR2_US),
	parameter DUR3_CYC   = `RGC_CYC(`RGC_T_DUR3_US),
	parameter DUR4_CYC   = `RGC_CYC(`RGC_T_DUR4_US),
	parameter DUR5_CYC   = `RGC_CYC(`RGC_T_DUR5_US),
	parameter DUR6_CYC   = `RGC_CYC(`RGC_T_DUR6_US)
) (
	input  wire        core_clk,
	input  wire        rst,
	// register port from the serial engine
	input  wire        regWrEn,
	input  wire        regRdEn,
	input  wire [7:0]  regAddr,
	input  wire [15:0] regWrData,
	output reg  [15:0] regRdData,
	output reg         regRdValid,
	// alert sources
	input  wire        adapterSideAlert,
	input  wire        systemSideAlert,
	input  wire        reverseCurrentTrip,
	input  wire        reverseMode,
	output reg         throttleAlert_n,
	// fault restart and startup
	input  wire        faultEvent,
	input  wire        startRequest,
	input  wire        switchingActive,
	input  wire        rampAtTarget,
	input  wire        reverseSensePin,
	input  wire        forceReverseOverride,
	output reg         revRestartReady,
	output reg         fwdRestartReady,
	output reg         switchingStart,
	output reg         configReadReq,
	output reg         digitalRestart,
	// analog control levels
	output reg         ovProtEnable,
	output reg         uvProtEnable,
	output reg         overcurrentEnable,
	output reg         overcurrentThrHigh,
	output reg         revFastSwapEnable,
	output reg         fwdFastSwapEnable,
	output reg         forceBuck,
	output reg         forceBoost,
	output reg         forceBuckBoost,
	output reg         forceNoSwitch,
	output reg         loopGainHalf,
	output reg         inputLimitLoopEnable,
	output reg         setpointBufferOn,
	output reg         periodDouble,
	output reg         outputValidFlag,
	output reg         forwardSleep
);

	// ------------------------------------------------------------
	// timing counts
	// ------------------------------------------------------------
	// counts are cut to the timer width on purpose; the slow 1.3s default still fits 27 bits
	localparam integer T10_CYC  = `RGC_CYC(`RGC_T_10_US);
	localparam integer DEB0_CYC = `RGC_CYC(`RGC_T_DEB0_US);
	localparam [W-1:0] C_SLOW   = SLOW_CYC[W-1:0];
	localparam [W-1:0] C_MID    = MID_CYC[W-1:0];
	localparam [W-1:0] C_200    = T200_CYC[W-1:0];
	localparam [W-1:0] C_10     = T10_CYC[W-1:0];
	localparam [W-1:0] C_DEB0   = DEB0_CYC[W-1:0];

	// ------------------------------------------------------------
	// registers and register port
	// ------------------------------------------------------------
	reg [15:0] protCtl_q;
	reg [15:0] modeCtl_q;
	reg [15:0] alertCtl_q;
	reg        latchHeld_q;

	wire wrProt  = regWrEn && (regAddr == `RGC_ADDR_PROT);
	wire wrMode  = regWrEn && (regAddr == `RGC_ADDR_MODE);
	wire wrAlert = regWrEn && (regAddr == `RGC_ADDR_ALERT);
	wire digRst  = wrMode && regWrData[`RGC_M_DIG_RST];
	wire alertClr = wrAlert && regWrData[`RGC_A_CLEAR];

	// the self-acting bits are never stored, so they always read zero
	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			protCtl_q  <= `RGC_PROT_RESET;
			modeCtl_q  <= `RGC_MODE_RESET;
			alertCtl_q <= `RGC_ALERT_RESET;
		end else if (digRst) begin
			protCtl_q  <= `RGC_PROT_RESET;
			modeCtl_q  <= `RGC_MODE_RESET;
			alertCtl_q <= `RGC_ALERT_RESET;
		end else begin
			if (wrProt)
				protCtl_q <= regWrData & `RGC_PROT_MASK;
			if (wrMode)
				modeCtl_q <= regWrData & `RGC_MODE_MASK;
			if (wrAlert)
				alertCtl_q <= regWrData & `RGC_ALERT_MASK;
		end
	end

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			regRdData  <= 16'h0000;
			regRdValid <= 1'b0;
		end else begin
			regRdValid <= regRdEn;
			if (regRdEn) begin
				case (regAddr)
					`RGC_ADDR_PROT:  regRdData <= protCtl_q;
					`RGC_ADDR_MODE:  regRdData <= modeCtl_q;
					`RGC_ADDR_ALERT: regRdData <= alertCtl_q;
					default:         regRdData <= 16'h0000;
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// static control outputs
	// ------------------------------------------------------------
	wire [2:0] forceCode = modeCtl_q[`RGC_M_FORCE_HI:`RGC_M_FORCE_LO];

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ovProtEnable         <= 1'b0;
			uvProtEnable         <= 1'b0;
			overcurrentEnable    <= 1'b0;
			overcurrentThrHigh   <= 1'b0;
			revFastSwapEnable    <= 1'b0;
			fwdFastSwapEnable    <= 1'b0;
			forceBuck            <= 1'b0;
			forceBoost           <= 1'b0;
			forceBuckBoost       <= 1'b0;
			forceNoSwitch        <= 1'b0;
			loopGainHalf         <= 1'b0;
			inputLimitLoopEnable <= 1'b0;
			setpointBufferOn     <= 1'b0;
			periodDouble         <= 1'b0;
			outputValidFlag      <= 1'b0;
			forwardSleep         <= 1'b0;
		end else begin
			ovProtEnable         <= ~protCtl_q[`RGC_P_OV_DIS];
			uvProtEnable         <= ~protCtl_q[`RGC_P_UV_DIS];
			overcurrentEnable    <= ~protCtl_q[`RGC_P_WOC_DIS];
			overcurrentThrHigh   <= protCtl_q[`RGC_P_WOC_THR];
			revFastSwapEnable    <= protCtl_q[`RGC_P_REV_SWAP];
			fwdFastSwapEnable    <= protCtl_q[`RGC_P_FWD_SWAP];
			forceNoSwitch        <= (forceCode == 3'h4);
			forceBuck            <= (forceCode == 3'h5);
			forceBoost           <= (forceCode == 3'h6);
			forceBuckBoost       <= (forceCode == 3'h7);
			loopGainHalf         <= modeCtl_q[`RGC_M_GAIN_HALF];
			inputLimitLoopEnable <= ~modeCtl_q[`RGC_M_ILIM_DIS];
			setpointBufferOn     <= ~modeCtl_q[`RGC_M_REF_OFF];
			// doubling only matters while the stage runs buck-boost
			periodDouble         <= modeCtl_q[`RGC_M_PER_DBL];
			outputValidFlag      <= switchingActive &&
			                        (modeCtl_q[`RGC_M_PG_EARLY] || rampAtTarget);
			forwardSleep         <= alertCtl_q[`RGC_A_SLEEP] && !reverseSensePin &&
			                        !forceReverseOverride;
		end
	end

	// ------------------------------------------------------------
	// fault restart and startup debounce
	// ------------------------------------------------------------
	wire [W-1:0] fastRst = protCtl_q[`RGC_P_REV_RST] ? C_10 : C_200;
	wire [W-1:0] revRstVal = protCtl_q[`RGC_P_FAST_RST] ? fastRst :
	                         (protCtl_q[`RGC_P_REV_RST] ? C_MID : C_SLOW);
	wire [W-1:0] fwdRstVal = protCtl_q[`RGC_P_FAST_RST] ? fastRst :
	                         (protCtl_q[`RGC_P_FWD_RST] ? C_MID : C_SLOW);
	wire         startFast = reverseMode ? modeCtl_q[`RGC_M_REV_START] : modeCtl_q[`RGC_M_FWD_START];
	// a digital reset clears the start bits, so its restart uses the default debounce
	wire [W-1:0] startVal  = (startFast && !digRst) ? C_10 : C_200;
	wire         revDone;
	wire         fwdDone;
	wire         startDone;

	rgc_timer #(.W(W)) uRevRestart (
		.clk     (core_clk),
		.rst     (rst),
		.start   (faultEvent),
		.loadVal (revRstVal),
		.busy    (),
		.done    (revDone)
	);

	rgc_timer #(.W(W)) uFwdRestart (
		.clk     (core_clk),
		.rst     (rst),
		.start   (faultEvent),
		.loadVal (fwdRstVal),
		.busy    (),
		.done    (fwdDone)
	);

	// a digital reset restarts switching through the same debounce
	rgc_timer #(.W(W)) uStartup (
		.clk     (core_clk),
		.rst     (rst),
		.start   (startRequest || digRst),
		.loadVal (startVal),
		.busy    (),
		.done    (startDone)
	);

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			revRestartReady <= 1'b0;
			fwdRestartReady <= 1'b0;
			switchingStart  <= 1'b0;
			configReadReq   <= 1'b0;
			digitalRestart  <= 1'b0;
		end else begin
			revRestartReady <= revDone;
			fwdRestartReady <= fwdDone;
			switchingStart  <= startDone;
			configReadReq   <= startDone && !modeCtl_q[`RGC_M_NO_REREAD];
			digitalRestart  <= digRst;
		end
	end

	// ------------------------------------------------------------
	// throttle alert
	// ------------------------------------------------------------
	reg  [W-1:0] debCnt_q;
	reg  [W-1:0] durCnt_q;
	reg          alertOn_q;
	reg  [W-1:0] debVal;
	reg  [W-1:0] durVal;

	wire alertCond = adapterSideAlert || systemSideAlert ||
	                 (reverseMode && reverseCurrentTrip && !alertCtl_q[`RGC_A_REV_CUR]);

	always @* begin
		case (protCtl_q[`RGC_P_DEB_HI:`RGC_P_DEB_LO])
			2'h0:    debVal = C_DEB0;
			2'h1:    debVal = DEB1_CYC[W-1:0];
			2'h2:    debVal = DEB2_CYC[W-1:0];
			default: debVal = DEB3_CYC[W-1:0];
		endcase
		case (protCtl_q[`RGC_P_DUR_HI:`RGC_P_DUR_LO])
			3'h0:    durVal = DUR0_CYC[W-1:0];
			3'h1:    durVal = DUR1_CYC[W-1:0];
			3'h2:    durVal = DUR2_CYC[W-1:0];
			3'h3:    durVal = DUR3_CYC[W-1:0];
			3'h4:    durVal = DUR4_CYC[W-1:0];
			3'h5:    durVal = DUR5_CYC[W-1:0];
			3'h6:    durVal = DUR6_CYC[W-1:0];
			default: durVal = {W{1'b0}};
		endcase
	end

	wire debMet  = alertCond && (debCnt_q + {{(W-1){1'b0}}, 1'b1} >= debVal);
	wire durOver = (durCnt_q == {W{1'b0}});

	always @(posedge core_clk or posedge rst) begin
		if (rst) begin
			debCnt_q        <= {W{1'b0}};
			durCnt_q        <= {W{1'b0}};
			alertOn_q       <= 1'b0;
			latchHeld_q     <= 1'b0;
			throttleAlert_n <= 1'b1;
		end else begin
			// any gap in the condition restarts the debounce
			if (!alertCond || alertOn_q)
				debCnt_q <= {W{1'b0}};
			else if (!debMet)
				debCnt_q <= debCnt_q + {{(W-1){1'b0}}, 1'b1};
			if (!alertOn_q && debMet) begin
				alertOn_q <= 1'b1;
				durCnt_q  <= durVal;
			end else if (alertOn_q) begin
				if (!durOver)
					durCnt_q <= durCnt_q - {{(W-1){1'b0}}, 1'b1};
				else if (!alertCond && !latchHeld_q)
					alertOn_q <= 1'b0;
			end
			// a trip in the clearing cycle keeps the latch set
			if (!alertOn_q && debMet && alertCtl_q[`RGC_A_LATCH])
				latchHeld_q <= 1'b1;
			else if (alertClr || digRst || !alertCtl_q[`RGC_A_LATCH])
				latchHeld_q <= 1'b0;
			throttleAlert_n <= ~alertOn_q;
		end
	end

endmodule
`default_nettype wire

//--- bench/rgc_host_model.sv
`default_nettype none
module rgc_host_model (
	input  wire logic        core_clk,
	output logic             regWrEn,
	output logic             regRdEn,
	output logic [7:0]       regAddr,
	output logic [15:0]      regWrData,
	input  wire logic [15:0] regRdData,
	input  wire logic        regRdValid
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 8'h00;
		regWrData = 16'h0000;
	end
	// data is inverted when idle so a stale word never passes for a fresh one
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(negedge core_clk);
		regWrEn = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge core_clk);
		regWrEn = 1'b0;
		regWrData = ~d;
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		d = 16'hxxxx;
		@(negedge core_clk);
		regRdEn = 1'b1;
		regAddr = a;
		@(negedge core_clk);
		regRdEn = 1'b0;
		for (int i = 0; i < 3; i++) begin
			if (regRdValid === 1'b1) d = regRdData;
			@(negedge core_clk);
		end
	endtask
endmodule
`default_nettype wire

//--- bench/rgc_regulator_ctrl_sva.sv
`default_nettype none
module rgc_regulator_ctrl_sva (
	input wire logic        core_clk,
	input wire logic        rst,
	input wire logic        regWrEn,
	input wire logic [7:0]  regAddr,
	input wire logic [15:0] regWrData,
	input wire logic        ovProtEnable,
	input wire logic        uvProtEnable,
	input wire logic        overcurrentEnable,
	input wire logic        overcurrentThrHigh,
	input wire logic        loopGainHalf,
	input wire logic        periodDouble,
	input wire logic        forceBuckBoost,
	input wire logic        digitalRestart,
	input wire logic        configReadReq,
	input wire logic        switchingStart,
	input wire logic        switchingActive,
	input wire logic        outputValidFlag,
	input wire logic        reverseSensePin,
	input wire logic        forceReverseOverride,
	input wire logic        forwardSleep
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic wP;
	logic wM;
	assign wP = regWrEn && regAddr == 8'h3d;
	assign wM = regWrEn && regAddr == 8'h4c;
	AST_OV_OFF: assert property (wP ##1 !wM |=> ovProtEnable == !$past(regWrData[15], 2))
		else $error("over-voltage enable does not follow write");
	AST_UV_OFF: assert property (wP ##1 !wM |=> uvProtEnable == !$past(regWrData[14], 2))
		else $error("under-voltage enable does not follow write");
	AST_WOC: assert property (wP ##1 !wM |=> overcurrentEnable == !$past(regWrData[1], 2)
		&& overcurrentThrHigh == $past(regWrData[0], 2)) else $error("overcurrent controls wrong");
	AST_GAIN_PER: assert property ((wM && !regWrData[2]) ##1 !wM |=>
		{loopGainHalf, periodDouble} == {$past(regWrData[6], 2), $past(regWrData[1], 2)})
		else $error("gain or period level wrong");
	AST_FORCE_BB: assert property ((wM && !regWrData[2]) ##1 !wM |=>
		forceBuckBoost == (($past(regWrData, 2) & 16'h0700) == 16'h0700)) else $error("buck-boost force wrong");
	AST_DIG_RST: assert property (wM && regWrData[2] |=> digitalRestart ##1 !digitalRestart ##[0:1] ovProtEnable)
		else $error("digital reset pulse or default restore wrong");
	AST_CFG_REQ: assert property (configReadReq |-> switchingStart)
		else $error("config reread outside switching start");
	AST_PG: assert property (!switchingActive |=> !outputValidFlag)
		else $error("output valid without switching");
	AST_SLEEP: assert property (reverseSensePin || forceReverseOverride |=> !forwardSleep)
		else $error("forward sleep not overridden");
endmodule
bind rgc_regulator_ctrl rgc_regulator_ctrl_sva rgc_regulator_ctrl_sva_i (.*);
`default_nettype wire

//--- bench/rgc_regulator_ctrl_tb.sv
`default_nettype none
module rgc_regulator_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	// ----
	// shortened counts so the run stays brief
	// ----
	localparam int SLOW = 200, MID = 100, T200 = 50;
	localparam int DEB[4] = '{350, 20, 30, 40};
	localparam int DUR[8] = '{60, 90, 80, 50, 40, 30, 25, 0};
	logic core_clk = 0, rst = 1, regWrEn, regRdEn, regRdValid, aPrev, cfgAtStart;
	logic [7:0] regAddr;
	logic [15:0] regWrData, regRdData, rd;
	logic adapterSideAlert = 0, systemSideAlert = 0, reverseCurrentTrip = 0, reverseMode = 0;
	logic faultEvent = 0, startRequest = 0, switchingActive = 0, rampAtTarget = 0;
	logic reverseSensePin = 0, forceReverseOverride = 0;
	logic throttleAlert_n, revRestartReady, fwdRestartReady, switchingStart, configReadReq, digitalRestart;
	logic ovProtEnable, uvProtEnable, overcurrentEnable, overcurrentThrHigh, revFastSwapEnable;
	logic fwdFastSwapEnable, forceBuck, forceBoost, forceBuckBoost, forceNoSwitch, loopGainHalf;
	logic inputLimitLoopEnable, setpointBufferOn, periodDouble, outputValidFlag, forwardSleep;
	int err_count = 0, num_checks = 0, cnt = 0, tRev, tFwd, tStart, tLow, tHigh, nDr = 0, t0;
	rgc_regulator_ctrl #(.SLOW_CYC(SLOW), .MID_CYC(MID), .T200_CYC(T200), .DEB1_CYC(DEB[1]),
		.DEB2_CYC(DEB[2]), .DEB3_CYC(DEB[3]), .DUR0_CYC(DUR[0]), .DUR1_CYC(DUR[1]), .DUR2_CYC(DUR[2]),
		.DUR3_CYC(DUR[3]), .DUR4_CYC(DUR[4]), .DUR5_CYC(DUR[5]), .DUR6_CYC(DUR[6])) rgc_regulator_ctrl_i (.*);
	rgc_host_model rgc_host_model_i (.*);
	initial forever #10 core_clk = ~core_clk;
	// event times are stamped by cycle so delays are measured, not polled
	always @(posedge core_clk) begin
		cnt <= cnt + 1;
		aPrev <= throttleAlert_n;
		if (revRestartReady === 1'b1) tRev <= cnt;
		if (fwdRestartReady === 1'b1) tFwd <= cnt;
		if (switchingStart === 1'b1) begin
			tStart <= cnt;
			cfgAtStart <= configReadReq;
		end
		if (digitalRestart === 1'b1) nDr <= nDr + 1;
		if (aPrev === 1'b1 && throttleAlert_n === 1'b0) tLow <= cnt;
		if (aPrev === 1'b0 && throttleAlert_n === 1'b1) tHigh <= cnt;
	end
	// ----
	// helpers
	// ----
	task automatic cmp(string n, logic [15:0] e, logic [15:0] s);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic cmpN(string n, int e, int s);
		num_checks++;
		if (s < e || s > e + 4) begin
			err_count++;
			$display("MISMATCH %s expected %0d seen %0d", n, e, s);
		end
	endtask
	task automatic cyc(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic w(logic [7:0] a, logic [15:0] d);
		rgc_host_model_i.wr(a, d);
		cyc(2);
	endtask
	task automatic chkR(logic [7:0] a, logic [15:0] e);
		rgc_host_model_i.rd(a, rd);
		cmp("readback", e, rd);
	endtask
	task automatic levels(logic [15:0] p, logic [15:0] m);
		cmp("prot levels", p, {ovProtEnable, uvProtEnable, overcurrentEnable, overcurrentThrHigh,
			revFastSwapEnable, fwdFastSwapEnable});
		cmp("mode levels", m, {loopGainHalf, inputLimitLoopEnable, setpointBufferOn, periodDouble, forceBuckBoost});
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		t0 = cnt;
		cyc(1);
		s = 1'b0;
	endtask
	// ----
	// scenarios
	// ----
	task automatic t_regs;
		chkR(8'h3d, 16'h0000);
		chkR(8'h4c, 16'h0000);
		chkR(8'h4e, 16'h0000);
		levels(16'h0038, 16'h000c);
		cmp("alert idle", 16'h0001, throttleAlert_n);
		w(8'h3d, 16'hffff);
		w(8'h4c, 16'hfffb);
		w(8'h4e, 16'hfffd);
		w(8'h40, 16'hffff);
		chkR(8'h3d, 16'hffdb);
		chkR(8'h4c, 16'h9f6b);
		chkR(8'h4e, 16'h00c1);
		chkR(8'h40, 16'h0000);
		levels(16'h0007, 16'h0013);
		cmp("sleep", 16'h0001, forwardSleep);
		for (int m = 0; m < 8; m++) begin
			w(8'h4c, 16'(m) << 8);
			cmp("force mode", (m > 3) ? 16'h0080 >> m : 16'h0000,
				{forceNoSwitch, forceBuck, forceBoost, forceBuckBoost});
		end
		$display("register test done");
	endtask
	task automatic t_digrst;
		int n0;
		n0 = nDr;
		w(8'h3d, 16'hffff);
		t0 = cnt;
		w(8'h4c, 16'h0004);
		cmp("restart pulses", 16'h0001, 16'(nDr - n0));
		chkR(8'h3d, 16'h0000);
		chkR(8'h4c, 16'h0000);
		cyc(T200);
		cmpN("startup after reset", T200, tStart - t0);
		cmp("config reread", 16'h0001, cfgAtStart);
		w(8'h4c, 16'h8800);
		pulse(startRequest);
		cyc(510);
		cmpN("fast startup", 500, tStart - t0);
		cmp("reread skipped", 16'h0000, cfgAtStart);
		reverseMode = 1'b1;
		pulse(startRequest);
		cyc(T200 + 10);
		cmpN("reverse startup", T200, tStart - t0);
		reverseMode = 1'b0;
		$display("reset and startup test done");
	endtask
	task automatic t_restart;
		logic [15:0] tab[5] = '{16'h0000, 16'h2000, 16'h0800, 16'h1000, 16'h3000};
		int er[5] = '{SLOW, MID, SLOW, T200, 500};
		int ef[5] = '{SLOW, SLOW, MID, T200, 500};
		for (int k = 0; k < 5; k++) begin
			w(8'h3d, tab[k]);
			pulse(faultEvent);
			cyc(510);
			cmpN("reverse restart", er[k], tRev - t0);
			cmpN("forward restart", ef[k], tFwd - t0);
		end
		$display("restart test done");
	endtask
	task automatic t_alert;
		for (int i = 0; i < 4; i++) begin
			w(8'h3d, (16'(i) << 9) | 16'h01c0);
			systemSideAlert = 1'b1;
			t0 = cnt;
			cyc(DEB[i] + 10);
			cmpN("alert debounce", DEB[i], tLow - t0);
			systemSideAlert = 1'b0;
			cyc(10);
		end
		for (int i = 0; i < 8; i++) begin
			w(8'h3d, (16'(i) << 6) | 16'h0200);
			adapterSideAlert = 1'b1;
			cyc(DEB[1] + 2);
			adapterSideAlert = 1'b0;
			cyc(DUR[i] + 20);
			cmpN("alert duration", DUR[i], tHigh - tLow);
		end
		w(8'h4e, 16'h0001);
		adapterSideAlert = 1'b1;
		cyc(DEB[1] + 2);
		adapterSideAlert = 1'b0;
		cyc(20);
		cmp("alert latched", 16'h0000, throttleAlert_n);
		w(8'h4e, 16'h0003);
		cyc(2);
		cmp("alert cleared", 16'h0001, throttleAlert_n);
		chkR(8'h4e, 16'h0001);
		w(8'h4e, 16'h0080);
		reverseMode = 1'b1;
		reverseCurrentTrip = 1'b1;
		cyc(40);
		cmp("reverse trip masked", 16'h0001, throttleAlert_n);
		w(8'h4e, 16'h0000);
		cyc(30);
		cmp("reverse trip", 16'h0000, throttleAlert_n);
		reverseCurrentTrip = 1'b0;
		reverseMode = 1'b0;
		cyc(10);
		cmp("alert auto clear", 16'h0001, throttleAlert_n);
		$display("alert test done");
	endtask
	task automatic t_misc;
		switchingActive = 1'b1;
		cyc(2);
		cmp("valid before target", 16'h0000, outputValidFlag);
		rampAtTarget = 1'b1;
		cyc(2);
		cmp("valid at target", 16'h0001, outputValidFlag);
		rampAtTarget = 1'b0;
		w(8'h4c, 16'h0001);
		cmp("valid early", 16'h0001, outputValidFlag);
		switchingActive = 1'b0;
		w(8'h4e, 16'h0040);
		cmp("sleep on", 16'h0001, forwardSleep);
		reverseSensePin = 1'b1;
		cyc(2);
		cmp("sleep pin override", 16'h0000, forwardSleep);
		reverseSensePin = 1'b0;
		forceReverseOverride = 1'b1;
		cyc(2);
		cmp("sleep bit override", 16'h0000, forwardSleep);
		forceReverseOverride = 1'b0;
		$display("valid and sleep test done");
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		cyc(20);
		rst = 1'b0;
		t_regs;
		t_digrst;
		t_restart;
		t_alert;
		t_misc;
		conclude;
	end
endmodule
`default_nettype wire
